// [rtl/iraram_pkg.sv]
`default_nettype none
package iraram_pkg;
	localparam int         NUM_PORTS      = 2;
	localparam int         NUM_SLOTS      = 3;
	localparam int         ID_W           = 7;
	// register offsets within the selected receive port
	localparam logic [7:0] OFS_DP_CTL_TWO = 8'h5a;
	localparam logic [7:0] OFS_SER_ADDR   = 8'h5b;
	localparam logic [7:0] OFS_SER_ALIAS  = 8'h5c;
	localparam logic [7:0] OFS_TGT_SLOT0  = 8'h5d;
	localparam logic [7:0] OFS_TGT_SLOT1  = 8'h5e;
	localparam logic [7:0] OFS_TGT_SLOT2  = 8'h5f;
	// field positions
	localparam int         ID_MSB         = 7;
	localparam int         ID_LSB         = 1;
	localparam int         HOLD_BIT       = 0;
	localparam int         AUTO_ACK_BIT   = 0;
	// reset values and the alias value that disables matching
	localparam logic [7:0] RST_DP_CTL_TWO = 8'h00;
	localparam logic [6:0] RST_SER_ADDR   = 7'h00;
	localparam logic       RST_HOLD       = 1'b0;
	localparam logic [6:0] RST_SER_ALIAS  = 7'h00;
	localparam logic       RST_AUTO_ACK   = 1'b0;
	localparam logic [6:0] RST_TGT_ADDR   = 7'h00;
	localparam logic [6:0] ALIAS_OFF      = 7'h00;

	typedef enum logic [1:0] {
		IRARAM_IDLE = 2'b00,
		IRARAM_WAIT = 2'b01
	} iraram_state_e;

	typedef logic [NUM_SLOTS-1:0][ID_W-1:0] iraram_slots_t;
endpackage : iraram_pkg
`default_nettype wire

// [rtl/iraram_port_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface iraram_port_if;
	import iraram_pkg::*;
	logic                 wr;
	logic [7:0]           addr;
	logic [7:0]           wdata;
	logic [7:0]           rdata;
	logic                 fwd_load;
	logic [ID_W-1:0]      fwd_id;
	logic [ID_W-1:0]      ser_addr;
	logic [ID_W-1:0]      ser_alias;
	logic                 auto_ack;
	iraram_slots_t        tgt;
	modport regs (input wr, addr, wdata, fwd_load, fwd_id,
		output rdata, ser_addr, ser_alias, auto_ack, tgt);
	modport ctrl (output wr, addr, wdata, fwd_load, fwd_id,
		input rdata, ser_addr, ser_alias, auto_ack, tgt);
endinterface : iraram_port_if
`default_nettype wire

// [rtl/iraram_port_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module iraram_port_regs
	import iraram_pkg::*;
(
	input  wire logic    sys_clk_in,
	input  wire logic    rstn_in,
	iraram_port_if.regs  pif
);
	typedef struct packed {
		logic [7:0]      dp_ctl_two;
		logic [ID_W-1:0] ser_addr;
		logic            hold;
		logic [ID_W-1:0] ser_alias;
		logic            auto_ack;
		iraram_slots_t   tgt;
	} iraram_regs_s;

	iraram_regs_s q;
	iraram_regs_s d;
	logic [7:0]   rd;

	always_comb begin
		d = q;
		if (pif.fwd_load && !q.hold) begin
			d.ser_addr = pif.fwd_id;
		end
		if (pif.wr) begin
			case (pif.addr)
				OFS_DP_CTL_TWO: d.dp_ctl_two = pif.wdata;
				OFS_SER_ADDR: begin
					d.ser_addr = pif.wdata[ID_MSB:ID_LSB];
					d.hold     = pif.wdata[HOLD_BIT];
				end
				OFS_SER_ALIAS: begin
					d.ser_alias = pif.wdata[ID_MSB:ID_LSB];
					d.auto_ack  = pif.wdata[AUTO_ACK_BIT];
				end
				default: d.dp_ctl_two = q.dp_ctl_two;
			endcase
			for (int k = 0; k < NUM_SLOTS; k++) begin
				if (pif.addr == 8'(OFS_TGT_SLOT0 + 8'(k))) begin
					d.tgt[k] = pif.wdata[ID_MSB:ID_LSB];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q <= '{dp_ctl_two: RST_DP_CTL_TWO, ser_addr: RST_SER_ADDR, hold: RST_HOLD,
				ser_alias: RST_SER_ALIAS, auto_ack: RST_AUTO_ACK,
				tgt: {NUM_SLOTS{RST_TGT_ADDR}}};
		end else begin
			q <= d;
		end
	end

	always_comb begin
		rd = 8'h00;
		case (pif.addr)
			OFS_DP_CTL_TWO: rd = q.dp_ctl_two;
			OFS_SER_ADDR:   rd = {q.ser_addr, q.hold};
			OFS_SER_ALIAS:  rd = {q.ser_alias, q.auto_ack};
			OFS_TGT_SLOT0:  rd = {q.tgt[0], 1'b0};
			OFS_TGT_SLOT1:  rd = {q.tgt[1], 1'b0};
			OFS_TGT_SLOT2:  rd = {q.tgt[2], 1'b0};
			default:        rd = 8'h00;
		endcase
	end

	assign pif.rdata     = rd;
	assign pif.ser_addr  = q.ser_addr;
	assign pif.ser_alias = q.ser_alias;
	assign pif.auto_ack  = q.auto_ack;
	assign pif.tgt       = q.tgt;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	fwd_load_a: assert property (pif.fwd_load && !q.hold && !pif.wr |=>
		q.ser_addr == $past(pif.fwd_id))
		else $error("serializer address not loaded from forward link");
	hold_keep_a: assert property (q.hold && !pif.wr |=> $stable(q.ser_addr))
		else $error("held serializer address changed");
	tgt_lsb_a: assert property (pif.addr >= OFS_TGT_SLOT0 && pif.addr <= OFS_TGT_SLOT2
		|-> rd[0] == 1'b0)
		else $error("target address bit zero not zero");
endmodule : iraram_port_regs
`default_nettype wire

// [rtl/iraram_top.sv]
// Functional notes
// - Each receive port has its own copy of these registers and reads and writes reach the copy of the selected port.
// - The serializer address field is loaded from the forward link of its port and resets to zero.
// - With the hold bit set, forward-link loading stops and the software-written address is kept.
// - A local address equal to the serializer alias is forwarded with the serializer address substituted.
// - A serializer alias of zero disables matching through that alias.
// - With auto-acknowledge set every write to the serializer is acknowledged, else the remote answer is relayed, or a nack given with pass-through off.
// - A match on a target slot alias is forwarded with that slot's physical address substituted.
// - Matched transactions are forwarded only while the port's pass-through enable is set.
`timescale 1ns/100ps
`default_nettype none
module iraram_top
	import iraram_pkg::*;
(
	input  wire logic                                sys_clk_in,
	input  wire logic                                rstn_in,
	input  wire logic                                rx_port_select_in,
	input  wire logic                                reg_wr_in,
	input  wire logic                                reg_rd_in,
	input  wire logic [7:0]                          reg_addr_in,
	input  wire logic [7:0]                          reg_wdata_in,
	output var  logic [7:0]                          reg_rdata_out,
	output var  logic                                reg_rdata_valid_out,
	input  wire logic [NUM_PORTS-1:0]                fwd_id_valid_in,
	input  wire logic [NUM_PORTS-1:0][ID_W-1:0]      fwd_id_in,
	input  wire logic [NUM_PORTS-1:0]                passthru_en_in,
	input  wire iraram_slots_t [NUM_PORTS-1:0]       target_alias_in,
	input  wire logic                                req_valid_in,
	input  wire logic [ID_W-1:0]                     req_addr_in,
	input  wire logic                                req_read_in,
	input  wire logic                                remote_ack_valid_in,
	input  wire logic                                remote_ack_in,
	output var  logic                                fwd_valid_out,
	output var  logic                                fwd_port_out,
	output var  logic [ID_W-1:0]                     fwd_addr_out,
	output var  logic                                fwd_read_out,
	output var  logic                                local_ack_valid_out,
	output var  logic                                local_ack_out
);
	typedef struct packed {
		iraram_state_e   state;
		logic            fwd_valid;
		logic            fwd_port;
		logic [ID_W-1:0] fwd_addr;
		logic            fwd_read;
		logic            lack_valid;
		logic            lack;
		logic            auto_done;
		logic [7:0]      rdata;
		logic            rvalid;
	} iraram_ctl_s;

	iraram_ctl_s                       q;
	iraram_ctl_s                       d;
	logic [NUM_PORTS-1:0][7:0]         rd_v;
	logic [NUM_PORTS-1:0][ID_W-1:0]    ser_addr_v;
	logic [NUM_PORTS-1:0][ID_W-1:0]    ser_alias_v;
	logic [NUM_PORTS-1:0]              auto_v;
	iraram_slots_t [NUM_PORTS-1:0]     tgt_v;
	logic                              hit;
	logic                              hit_ser;
	logic                              hit_port;
	logic [ID_W-1:0]                   hit_phys;
	logic                              auto_now;

	iraram_port_if pif [NUM_PORTS] ();

	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		assign pif[g].wr       = reg_wr_in && (rx_port_select_in == 1'(g));
		assign pif[g].addr     = reg_addr_in;
		assign pif[g].wdata    = reg_wdata_in;
		assign pif[g].fwd_load = fwd_id_valid_in[g];
		assign pif[g].fwd_id   = fwd_id_in[g];
		assign rd_v[g]         = pif[g].rdata;
		assign ser_addr_v[g]   = pif[g].ser_addr;
		assign ser_alias_v[g]  = pif[g].ser_alias;
		assign auto_v[g]       = pif[g].auto_ack;
		assign tgt_v[g]        = pif[g].tgt;

		iraram_port_regs u_regs (
			.sys_clk_in (sys_clk_in),
			.rstn_in    (rstn_in),
			.pif        (pif[g])
		);
	end

	// alias decode, port 0 serializer alias has highest priority
	always_comb begin
		hit      = 1'b0;
		hit_ser  = 1'b0;
		hit_port = 1'b0;
		hit_phys = '0;
		for (int p = NUM_PORTS - 1; p >= 0; p--) begin
			for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
				if (target_alias_in[p][k] != ALIAS_OFF
					&& req_addr_in == target_alias_in[p][k]) begin
					hit      = 1'b1;
					hit_ser  = 1'b0;
					hit_port = 1'(p);
					hit_phys = tgt_v[p][k];
				end
			end
			if (ser_alias_v[p] != ALIAS_OFF && req_addr_in == ser_alias_v[p]) begin
				hit      = 1'b1;
				hit_ser  = 1'b1;
				hit_port = 1'(p);
				hit_phys = ser_addr_v[p];
			end
		end
	end

	assign auto_now = hit_ser && !req_read_in && auto_v[hit_port];

	always_comb begin
		d            = q;
		d.fwd_valid  = 1'b0;
		d.lack_valid = 1'b0;
		d.rvalid     = reg_rd_in;
		if (reg_rd_in) begin
			d.rdata = rd_v[rx_port_select_in];
		end
		case (q.state)
			IRARAM_IDLE: begin
				if (req_valid_in && hit) begin
					if (passthru_en_in[hit_port]) begin
						d.fwd_valid = 1'b1;
						d.fwd_port  = hit_port;
						d.fwd_addr  = hit_phys;
						d.fwd_read  = req_read_in;
						d.auto_done = auto_now;
						d.state     = IRARAM_WAIT;
						if (auto_now) begin
							d.lack_valid = 1'b1;
							d.lack       = 1'b1;
						end
					end else begin
						d.lack_valid = 1'b1;
						d.lack       = auto_now;
					end
				end
			end
			IRARAM_WAIT: begin
				if (remote_ack_valid_in) begin
					d.state = IRARAM_IDLE;
					if (!q.auto_done) begin
						d.lack_valid = 1'b1;
						d.lack       = remote_ack_in;
					end
				end
			end
			default: begin
				d.state = IRARAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q <= '{state: IRARAM_IDLE, fwd_valid: 1'b0, fwd_port: 1'b0, fwd_addr: '0,
				fwd_read: 1'b0, lack_valid: 1'b0, lack: 1'b0, auto_done: 1'b0,
				rdata: 8'h00, rvalid: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_out       = q.rdata;
	assign reg_rdata_valid_out = q.rvalid;
	assign fwd_valid_out       = q.fwd_valid;
	assign fwd_port_out        = q.fwd_port;
	assign fwd_addr_out        = q.fwd_addr;
	assign fwd_read_out        = q.fwd_read;
	assign local_ack_valid_out = q.lack_valid;
	assign local_ack_out       = q.lack;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence auto_write_s;
		q.state == IRARAM_IDLE && req_valid_in && hit_ser && !req_read_in
			&& auto_v[hit_port];
	endsequence

	sequence fwd_then_remote_s;
		q.state == IRARAM_WAIT && !q.auto_done && remote_ack_valid_in;
	endsequence

	sel_read_a: assert property (reg_rd_in |=> reg_rdata_valid_out
		&& reg_rdata_out == $past(rd_v[rx_port_select_in]))
		else $error("read data not from selected port");
	sel_write_a: assert property (reg_wr_in && rx_port_select_in == 1'b0
		&& reg_addr_in == OFS_SER_ALIAS |=> ser_alias_v[1] == $past(ser_alias_v[1]))
		else $error("write reached unselected port");
	auto_ack_a: assert property (auto_write_s |=> local_ack_valid_out
		&& local_ack_out)
		else $error("auto acknowledge missing");
	relay_ack_a: assert property (fwd_then_remote_s |=> local_ack_valid_out
		&& local_ack_out == $past(remote_ack_in))
		else $error("remote acknowledge not relayed");
	no_double_a: assert property (q.auto_done && q.state == IRARAM_WAIT
		&& remote_ack_valid_in |=> !local_ack_valid_out)
		else $error("second acknowledge after auto acknowledge");
	remap_a: assert property (q.state == IRARAM_IDLE && req_valid_in && hit
		&& passthru_en_in[hit_port] |=> fwd_valid_out
		&& fwd_addr_out == $past(hit_phys) && fwd_port_out == $past(hit_port))
		else $error("forwarded address not remapped");
	zero_alias_a: assert property (q.state == IRARAM_IDLE && req_valid_in
		&& req_addr_in == ALIAS_OFF |=> !fwd_valid_out && !local_ack_valid_out)
		else $error("match through zero alias");
	fwd_dir_a: assert property (q.state == IRARAM_IDLE && req_valid_in && hit
		&& passthru_en_in[hit_port] |=> fwd_read_out == $past(req_read_in))
		else $error("forwarded direction differs from request");
	idle_quiet_a: assert property (q.state == IRARAM_IDLE && !(req_valid_in && hit)
		|=> !fwd_valid_out && !local_ack_valid_out)
		else $error("output without matching request");
	passthru_a: assert property (req_valid_in && passthru_en_in == '0
		|=> !fwd_valid_out)
		else $error("forwarded with pass-through off");
	wait_enter_a: assert property (fwd_valid_out |-> q.state == IRARAM_WAIT)
		else $error("forward without wait state");
	wait_leave_a: assert property (q.state == IRARAM_WAIT && !remote_ack_valid_in
		|=> q.state == IRARAM_WAIT && !fwd_valid_out)
		else $error("wait state left without remote answer");
endmodule : iraram_top
`default_nettype wire

// [sim/iraram_ser_model.sv]
`timescale 1ns/100ps
`default_nettype none
module iraram_ser_model (
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       fwd_valid_in,
	input  wire logic       ack_val_in,
	input  wire logic [2:0] delay_in,
	output var  logic       ack_valid_out,
	output var  logic       ack_out
);
	logic [3:0] cnt_q;
	// answers each forward after delay_in+1 cycles; idle line toggles
	always @(negedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= 4'h0;
			ack_valid_out <= 1'b0;
			ack_out <= 1'b0;
		end else begin
			ack_valid_out <= 1'b0;
			ack_out <= ~ack_out;
			if (fwd_valid_in) begin
				cnt_q <= {1'b0, delay_in} + 4'h1;
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					ack_valid_out <= 1'b1;
					ack_out <= ack_val_in;
				end
			end
		end
	end
endmodule : iraram_ser_model
`default_nettype wire

// [sim/i2c_remote_alias_remap_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module i2c_remote_alias_remap_bench;
	import iraram_pkg::*;
	logic                           clk, rstn, sel, wr, rd, req, req_rd, rav, ra;
	logic                           rvalid, fv, fp, lav, la, pack, r, fr;
	logic [7:0]                     addr, wdata, rdata, d;
	logic [ID_W-1:0]                req_addr, fa, sa, al, v;
	logic [NUM_PORTS-1:0]           fidv, pt;
	logic [NUM_PORTS-1:0][ID_W-1:0] fid;
	iraram_slots_t [NUM_PORTS-1:0]  ta;
	iraram_slots_t                  ph;
	logic [2:0]                     dly;
	logic [7:0]                     sh [2][6];
	int                             failures, compares;

	always #25 clk = ~clk;

	iraram_top u_dut (.sys_clk_in(clk), .rstn_in(rstn), .rx_port_select_in(sel),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid), .fwd_id_valid_in(fidv),
		.fwd_id_in(fid), .passthru_en_in(pt), .target_alias_in(ta), .req_valid_in(req),
		.req_addr_in(req_addr), .req_read_in(req_rd), .remote_ack_valid_in(rav),
		.remote_ack_in(ra), .fwd_valid_out(fv), .fwd_port_out(fp), .fwd_addr_out(fa),
		.fwd_read_out(fr), .local_ack_valid_out(lav), .local_ack_out(la));

	iraram_ser_model u_ser (.clk_in(clk), .rstn_in(rstn), .fwd_valid_in(fv),
		.ack_val_in(pack), .delay_in(dly), .ack_valid_out(rav), .ack_out(ra));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wreg(input logic p, input logic [7:0] a, input logic [7:0] w);
		@(negedge clk);
		sel = p;
		wr = 1'b1;
		addr = a;
		wdata = w;
		@(negedge clk);
		wr = 1'b0;
	endtask : wreg

	task automatic rreg(input logic p, input logic [7:0] a);
		@(negedge clk);
		sel = p;
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		chk({7'h00, rvalid}, 8'h01);
		d = rdata;
	endtask : rreg

	task automatic fload(input int p, input logic [6:0] id);
		@(negedge clk);
		fidv[p] = 1'b1;
		fid[p] = id;
		@(negedge clk);
		fidv = '0;
		fid[p] = ~id;
	endtask : fload

	function automatic logic [7:0] exp_reg(input logic [7:0] a, input logic [7:0] w);
		case (a)
			OFS_SER_ADDR, OFS_SER_ALIAS: return w;
			OFS_TGT_SLOT0, OFS_TGT_SLOT1, OFS_TGT_SLOT2: return w & 8'hfe;
			default: return 8'h00;
		endcase
	endfunction : exp_reg

	// one request, then count forwards and local answers over a fixed window
	task automatic txn(input logic [6:0] a, input logic rw, input logic rack,
		input logic p, input int nfe, input logic [6:0] ea, input int nae, input logic eak);
		int         nf;
		int         na;
		logic       fpq;
		logic       akq;
		logic       frq;
		logic [6:0] faq;
		nf = 0;
		na = 0;
		@(negedge clk);
		req = 1'b1;
		req_addr = a;
		req_rd = rw;
		pack = rack;
		dly = 3'($urandom_range(0, 5));
		@(negedge clk);
		req = 1'b0;
		req_addr = ~a;
		for (int i = 0; i < 12; i++) begin
			if (fv === 1'b1) begin
				nf++;
				fpq = fp;
				faq = fa;
				frq = fr;
			end
			if (lav === 1'b1) begin
				na++;
				akq = la;
			end
			@(negedge clk);
		end
		chk(8'(nf), 8'(nfe));
		chk(8'(na), 8'(nae));
		if (nfe > 0) chk({fpq, faq}, {p, ea});
		if (nfe > 0) chk({7'h00, frq}, {7'h00, rw});
		if (nae > 0) chk({7'h00, akq}, {7'h00, eak});
	endtask : txn

	task automatic summarize();
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	initial begin
		failures = 0;
		compares = 0;
		clk = 1'b0;
		{rstn, sel, wr, rd, req, req_rd, pack} = '0;
		{addr, wdata, req_addr, fidv, fid, pt, ta, dly} = '0;
		void'($urandom(32'h765d_d903));
		repeat (10) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		for (int p = 0; p < 2; p++)
			for (int a = 8'h59; a <= 8'h60; a++) begin
				rreg(p[0], 8'(a));
				chk(d, 8'h00);
			end
		for (int p = 0; p < 2; p++)
			for (int a = 0; a < 6; a++) begin
				sh[p][a] = 8'($urandom);
				wreg(p[0], 8'h5b + 8'(a), sh[p][a]);
			end
		for (int p = 0; p < 2; p++)
			for (int a = 0; a < 6; a++) begin
				rreg(p[0], 8'h5b + 8'(a));
				chk(d, exp_reg(8'h5b + 8'(a), sh[p][a]));
			end
		for (int p = 0; p < 2; p++) begin
			v = 7'($urandom);
			wreg(p[0], OFS_SER_ADDR, 8'h00);
			fload(p, v);
			rreg(p[0], OFS_SER_ADDR);
			chk(d, {v, 1'b0});
			wreg(p[0], OFS_SER_ADDR, {~v, 1'b1});
			fload(p, v);
			rreg(p[0], OFS_SER_ADDR);
			chk(d, {~v, 1'b1});
		end
		for (int p = 0; p < 2; p++) begin
			sa = 7'($urandom);
			al = 7'($urandom_range(1, 15));
			ph = iraram_slots_t'($urandom);
			r = 1'($urandom);
			pt = '0;
			pt[p] = 1'b1;
			ta = '0;
			wreg(~p[0], OFS_SER_ALIAS, 8'h00);
			for (int s = 0; s < 3; s++) begin
				ta[p][s] = 7'h40 + 7'(s);
				wreg(p[0], OFS_TGT_SLOT0 + 8'(s), {ph[s], 1'b0});
			end
			wreg(p[0], OFS_SER_ADDR, {sa, 1'b1});
			wreg(p[0], OFS_SER_ALIAS, {al, 1'b0});
			txn(al, 1'b0, r, p[0], 1, sa, 1, r);
			for (int s = 0; s < 3; s++)
				txn(ta[p][s], 1'b1, ~r, p[0], 1, ph[s], 1, ~r);
			wreg(p[0], OFS_SER_ALIAS, {al, 1'b1});
			txn(al, 1'b0, 1'b0, p[0], 1, sa, 1, 1'b1);
			txn(al, 1'b1, 1'b0, p[0], 1, sa, 1, 1'b0);
			pt = '0;
			txn(al, 1'b0, 1'b0, p[0], 0, sa, 1, 1'b1);
			wreg(p[0], OFS_SER_ALIAS, {al, 1'b0});
			txn(al, 1'b0, 1'b1, p[0], 0, sa, 1, 1'b0);
			pt[p] = 1'b1;
			wreg(p[0], OFS_SER_ALIAS, 8'h00);
			txn(7'h00, 1'b0, 1'b1, p[0], 0, sa, 0, 1'b0);
			txn(al, 1'b0, 1'b1, p[0], 0, sa, 0, 1'b0);
		end
		summarize();
	end
endmodule : i2c_remote_alias_remap_bench
`default_nettype wire
